// ### hdl/csd_consts.vh
// constants of the chip-select decoder: indices, field positions, resets
// assumes inclusion by every design file of the decoder
`ifndef CSD_CONSTS_VH
`define CSD_CONSTS_VH

// ****************************************************************
// select indices
// ****************************************************************
`define CSD_N_SEL        5
`define CSD_IDX_BOOT     0
`define CSD_IDX_BANK1    1
`define CSD_IDX_ATA      2
`define CSD_IDX_PINLESS  3
`define CSD_IDX_ROMPIN   4

// ****************************************************************
// programming port: which register a write or read reaches
// ****************************************************************
`define CSD_KIND_BASE    2'h0
`define CSD_KIND_MASK    2'h1
`define CSD_KIND_CTRL    2'h2

// ****************************************************************
// select_mask_reg fields
// ****************************************************************
`define CSD_MASK_VALID   0
`define CSD_MASK_WP      8

// ****************************************************************
// select_control_reg fields
// ****************************************************************
`define CSD_CTRL_WS_HI   13
`define CSD_CTRL_WS_LO   10
`define CSD_CTRL_AA      8
`define CSD_CTRL_PS_HI   7
`define CSD_CTRL_PS_LO   6
`define CSD_CTRL_BEM     5
`define CSD_CTRL_BSTR    4
`define CSD_CTRL_BSTW    3
`define CSD_CTRL_BOOT_RST 16'h3DA0
`define CSD_CTRL_ZERO    16'h0000
`define CSD_PS_16BIT     2'h2

// ****************************************************************
// ata_config_first fields
// ****************************************************************
`define CSD_ATA_RD_ON_WR 0
`define CSD_ATA_WAIT_HI  15
`define CSD_ATA_WAIT_LO  8
`define CSD_ATA_PINLESS_BUF1 18
`define CSD_ATA_PINLESS_BUF2 21

`endif

// ### hdl/csd_decoder.v
// chip-select decoder and strobe generator of the external memory bus
// assumes one core cycle request held until done or dropped by a watchdog

`include "csd_consts.vh"

// Function
// - after power-on all cycles go to boot_select
// - address line 23 strap picks boot source
// - rom boot: boot internal, pin is rom_pin_select
// - reset clears bank-one select programming
// - ata read/write strobes, read strobe optionally on writes
// - ata cycles: long waits, extended by ata_ready_in
// - pinless select can drive buffer enables
// - output enable on any read match, falling edge
// - buffer_enable_first on every boot cycle
// - buffer_enable_second never boot, else programmable
// - base, 32-bit mask, control register per select
// - no match leaves cycle unterminated
// - single match runs from that control register
// - multiple matches assert all, await transfer_ack_in
// - port width expected 16 bits
// - global mode: boot_select on every access only
// - internal_to_external_ctl sends internal cycles out
// - global mode ends when boot valid set
// - boot reset: auto_acknowledge, 15 waits, 16-bit
// - boot base loaded first keeps decoding after valid
// - global mode only returns through reset
// - base compared against core address 31..16
// - reset clears every valid bit, bank-one base and mask, and every control but boot's
module csd_decoder (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_strap_a23,
  input  wire        i_wr_en,
  input  wire [2:0]  i_wr_idx,
  input  wire [1:0]  i_wr_kind,
  input  wire [31:0] i_wr_data,
  input  wire [2:0]  i_rd_idx,
  input  wire [1:0]  i_rd_kind,
  output reg  [31:0] o_rd_data,
  input  wire [31:0] i_ata_config_first,
  input  wire [3:0]  i_buf2_enable,
  input  wire        i_int_to_ext_ctl,
  input  wire        i_cyc_req,
  input  wire        i_cyc_internal,
  input  wire        i_cyc_write,
  input  wire [31:0] i_cyc_addr,
  input  wire        i_transfer_ack_in_n,
  input  wire        i_ata_ready_in,
  output wire        o_cyc_ack,
  output wire        o_cyc_hang,
  output wire [1:0]  o_port_width,
  output wire        o_burst,
  output wire        o_boot_rom_sel,
  output wire        o_shared_select_n,
  output wire        o_bank_one_select_n,
  output wire        o_ata_read_strobe_n,
  output wire        o_ata_write_strobe_n,
  output wire        o_read_enable_n,
  output wire        o_buffer_enable_first_n,
  output wire        o_buffer_enable_second_n,
  output wire        o_global_mode,
  output wire        o_boot_from_rom
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_WAIT = 5'b00010;
  localparam [4:0] ST_TERM = 5'b00100;
  localparam [4:0] ST_ACK  = 5'b01000;
  localparam [4:0] ST_ERR  = 5'b10000;

  // ****************************************************************
  // programming registers
  // ****************************************************************
  reg  [15:0] base_q [0:`CSD_N_SEL-1];
  reg  [31:0] mask_q [0:`CSD_N_SEL-1];
  reg  [15:0] ctrl_q [0:`CSD_N_SEL-1];
  reg  [4:0]  valid_q;
  reg         global_q;
  reg         boot_rom_q;
  integer     k;

  // base, mask and control per select
  always @(posedge i_clk) begin
    if (i_srst) begin
      valid_q <= 5'h00;
      for (k = 0; k < `CSD_N_SEL; k = k + 1) begin
        ctrl_q[k] <= `CSD_CTRL_ZERO;
      end
      ctrl_q[`CSD_IDX_BOOT] <= `CSD_CTRL_BOOT_RST;
      base_q[`CSD_IDX_BANK1] <= 16'h0000;
      mask_q[`CSD_IDX_BANK1] <= 32'h0000_0000;
    end else if (i_wr_en && (i_wr_idx < 3'h5)) begin
      // base is kept even while global, so it applies once valid
      if (i_wr_kind == `CSD_KIND_BASE) begin
        base_q[i_wr_idx] <= i_wr_data[31:16];
      end else if (i_wr_kind == `CSD_KIND_MASK) begin
        mask_q[i_wr_idx] <= i_wr_data;
        valid_q[i_wr_idx] <= i_wr_data[`CSD_MASK_VALID];
      end else if (i_wr_kind == `CSD_KIND_CTRL) begin
        // only a 16-bit port exists; software keeps the field at 16
        ctrl_q[i_wr_idx] <= i_wr_data[15:0];
      end
    end
  end

  // ****************************************************************
  // global mode and boot strap
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_srst) begin
      global_q <= 1'b1;
      // strap sampled throughout reset, last value kept at release
      boot_rom_q <= ~i_strap_a23;
    end else if (valid_q[`CSD_IDX_BOOT]) begin
      // only clears; no write path sets it again
      global_q <= 1'b0;
    end
  end

  // register readback; base low half and control upper half read zero, unused mask bits read back as written
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_data <= 32'h0000_0000;
    end else if (i_rd_idx >= 3'h5) begin
      o_rd_data <= 32'h0000_0000;
    end else if (i_rd_kind == `CSD_KIND_BASE) begin
      o_rd_data <= {base_q[i_rd_idx], 16'h0000};
    end else if (i_rd_kind == `CSD_KIND_MASK) begin
      o_rd_data <= {mask_q[i_rd_idx][31:1], valid_q[i_rd_idx]};
    end else if (i_rd_kind == `CSD_KIND_CTRL) begin
      o_rd_data <= {16'h0000, ctrl_q[i_rd_idx]};
    end else begin
      o_rd_data <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire [4:0] raw_hit;
  wire [4:0] hit;
  wire       take;
  wire       single;

  genvar g;
  generate
    for (g = 0; g < `CSD_N_SEL; g = g + 1) begin : g_dec
      csd_match u_match (
        .i_addr_hi (i_cyc_addr[31:16]),
        .i_base    (base_q[g]),
        .i_bam     (mask_q[g][31:16]),
        .i_valid   (valid_q[g]),
        .i_wp      (mask_q[g][`CSD_MASK_WP]),
        .i_write   (i_cyc_write),
        .o_hit     (raw_hit[g])
      );
    end
  endgenerate

  // internal cycles reach the pins only when sent out
  assign take = i_cyc_req & (~i_cyc_internal | i_int_to_ext_ctl);

  // fifth select has a pin only in rom boot; global forces boot alone
  assign hit = global_q ? 5'b00001 :
               (raw_hit & {boot_rom_q, 4'b1111});

  assign single = (hit != 5'h00) && ((hit & (hit - 5'h01)) == 5'h00);

  // settings of the lowest hit; only used when exactly one hits
  reg [15:0] hit_ctrl;
  integer    j;
  always @* begin
    hit_ctrl = `CSD_CTRL_ZERO;
    for (j = `CSD_N_SEL - 1; j >= 0; j = j - 1) begin
      if (hit[j]) begin
        hit_ctrl = ctrl_q[j];
      end
    end
  end

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  reg [4:0] st_q;
  reg [4:0] sel_q;
  reg [7:0] cnt_q;
  reg       aa_q;
  reg       ready_mode_q;
  reg       write_q;
  reg [1:0] ps_q;
  reg       burst_q;

  always @(posedge i_clk) begin
    if (i_srst) begin
      st_q         <= ST_IDLE;
      sel_q        <= 5'h00;
      cnt_q        <= 8'h00;
      aa_q         <= 1'b0;
      ready_mode_q <= 1'b0;
      write_q      <= 1'b0;
      ps_q         <= `CSD_PS_16BIT;
      burst_q      <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (take) begin
            write_q <= i_cyc_write;
            sel_q   <= hit; // every matching select asserts
            if (hit == 5'h00) begin
              st_q <= ST_ERR;
            end else if (!single) begin
              ready_mode_q <= 1'b0;
              st_q         <= ST_TERM;
            end else if (hit[`CSD_IDX_ATA]) begin
              // ata waits reach 255, then ready stretches the cycle
              cnt_q <= i_ata_config_first[`CSD_ATA_WAIT_HI:`CSD_ATA_WAIT_LO];
              ready_mode_q <= 1'b1;
              ps_q         <= hit_ctrl[`CSD_CTRL_PS_HI:`CSD_CTRL_PS_LO];
              burst_q      <= 1'b0;
              st_q         <= ST_WAIT;
            end else begin
              cnt_q <= {4'h0, hit_ctrl[`CSD_CTRL_WS_HI:`CSD_CTRL_WS_LO]};
              aa_q         <= hit_ctrl[`CSD_CTRL_AA];
              ps_q         <= hit_ctrl[`CSD_CTRL_PS_HI:`CSD_CTRL_PS_LO];
              burst_q      <= i_cyc_write ? hit_ctrl[`CSD_CTRL_BSTW]
                                          : hit_ctrl[`CSD_CTRL_BSTR];
              ready_mode_q <= 1'b0;
              st_q         <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (!i_cyc_req) begin
            sel_q <= 5'h00;
            st_q  <= ST_IDLE;
          end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (ready_mode_q || !aa_q) begin
            st_q <= ST_TERM; // external termination chosen
          end else begin
            st_q <= ST_ACK; // auto_acknowledge after the waits
          end
        end
        ST_TERM: begin
          if (!i_cyc_req) begin
            sel_q <= 5'h00;
            st_q  <= ST_IDLE;
          end else if (ready_mode_q ? i_ata_ready_in
                                    : !i_transfer_ack_in_n) begin
            st_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          sel_q <= 5'h00;
          st_q  <= ST_IDLE;
        end
        ST_ERR: begin
          // no acknowledge ever; only a dropped request frees the bus
          if (!i_cyc_req) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          sel_q <= 5'h00;
          st_q  <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_cyc_ack    = (st_q == ST_ACK);
  assign o_cyc_hang   = (st_q == ST_ERR);
  assign o_port_width = ps_q;
  assign o_burst      = burst_q;

  // ****************************************************************
  // pins
  // ****************************************************************
  wire boot_cyc;
  wire ata_cyc;
  wire pinless_cyc;

  assign boot_cyc    = sel_q[`CSD_IDX_BOOT];
  assign ata_cyc     = sel_q[`CSD_IDX_ATA];
  assign pinless_cyc = sel_q[`CSD_IDX_PINLESS];

  // rom boot serves boot cycles on chip; shared pin is the fifth
  assign o_boot_rom_sel    = boot_cyc & boot_rom_q;
  assign o_shared_select_n = boot_rom_q ? ~sel_q[`CSD_IDX_ROMPIN]
                                        : ~boot_cyc;
  assign o_bank_one_select_n = ~sel_q[`CSD_IDX_BANK1];

  assign o_ata_read_strobe_n = ~(ata_cyc & (~write_q |
                                 i_ata_config_first[`CSD_ATA_RD_ON_WR]));
  assign o_ata_write_strobe_n = ~(ata_cyc & write_q);

  // pinless select reaches the pins only through the buffer enables and the read enable
  assign o_buffer_enable_first_n = ~(boot_cyc |
    (pinless_cyc & i_ata_config_first[`CSD_ATA_PINLESS_BUF1]));

  assign o_buffer_enable_second_n = ~(~boot_cyc & (
    (sel_q[`CSD_IDX_BANK1]  & i_buf2_enable[0]) |
    (ata_cyc                & i_buf2_enable[1]) |
    (pinless_cyc & (i_buf2_enable[2] |
      i_ata_config_first[`CSD_ATA_PINLESS_BUF2])) |
    (sel_q[`CSD_IDX_ROMPIN] & i_buf2_enable[3])));

  // falling edge keeps the enable clear of the select edges
  reg oe_n_q;
  always @(negedge i_clk) begin
    if (i_srst) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= ~((sel_q != 5'h00) & ~write_q);
    end
  end

  assign o_read_enable_n = oe_n_q;
  assign o_global_mode   = global_q;
  assign o_boot_from_rom = boot_rom_q;

endmodule // csd_decoder

// ### hdl/csd_match.v
// one select's address comparator
// assumes the upper core address is stable while the cycle is requested
`include "csd_consts.vh"

module csd_match (
  input  wire [15:0] i_addr_hi,
  input  wire [15:0] i_base,
  input  wire [15:0] i_bam,
  input  wire        i_valid,
  input  wire        i_wp,
  input  wire        i_write,
  output wire        o_hit
);

  // ****************************************************************
  // compare
  // ****************************************************************
  wire [15:0] diff;

  // masked bits drop out of the compare, so blocks grow from 64 KB
  assign diff  = (i_addr_hi ^ i_base) & ~i_bam;
  // write-protected selects refuse writes as an attribute miss
  assign o_hit = i_valid & (diff == 16'h0000) & ~(i_wp & i_write);

endmodule // csd_match

// ### verification/csd_decoder_properties.sv
// port checks of the chip-select decoder
// assumes a bind into csd_decoder, one clock, synchronous reset
module csd_decoder_chk (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cyc_write,
  input wire logic i_ata_ready_in,
  input wire logic i_transfer_ack_in_n,
  input wire logic o_cyc_ack,
  input wire logic o_shared_select_n,
  input wire logic o_bank_one_select_n,
  input wire logic o_ata_read_strobe_n,
  input wire logic o_ata_write_strobe_n,
  input wire logic o_read_enable_n,
  input wire logic o_buffer_enable_second_n,
  input wire logic o_global_mode,
  input wire logic o_boot_from_rom
);
  // ****************
  // properties
  // ****************
  logic oe_pos_q;
  // taken at the rising edge, so a change there shows at the falling edge
  always @(posedge i_clk) oe_pos_q <= o_read_enable_n;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  rst_global_a: assert property ($past(i_srst) |-> o_global_mode)
    else $error("global mode missing after reset");
  boot_wait_a: assert property (
    o_global_mode && !o_boot_from_rom && $fell(o_shared_select_n)
    |-> !o_cyc_ack [*8] ##9 o_cyc_ack) else $error("boot ack timing wrong");
  buf2_boot_a: assert property (
    !o_shared_select_n && !o_boot_from_rom |-> o_buffer_enable_second_n)
    else $error("second buffer on boot cycle");
  global_only_a: assert property (
    o_global_mode |-> o_bank_one_select_n && o_ata_read_strobe_n && o_ata_write_strobe_n)
    else $error("other select in global mode");
  ata_ready_a: assert property (
    (!o_ata_read_strobe_n || !o_ata_write_strobe_n) && !i_ata_ready_in |=> !o_cyc_ack)
    else $error("ata ack while not ready");
  multi_ext_a: assert property (
    !o_bank_one_select_n && !o_ata_read_strobe_n && i_transfer_ack_in_n |=> !o_cyc_ack)
    else $error("multi match ack without termination");
  oe_match_a: assert property (@(negedge i_clk) disable iff (i_srst)
    !o_bank_one_select_n && !i_cyc_write |=> !o_read_enable_n)
    else $error("read enable missing on match");
  oe_edge_a: assert property (@(negedge i_clk) disable iff (i_srst)
    o_read_enable_n == oe_pos_q) else $error("read enable moved on rising edge");
endmodule // csd_decoder_chk

bind csd_decoder csd_decoder_chk chk_u (.i_clk, .i_srst, .i_cyc_write, .i_ata_ready_in,
  .i_transfer_ack_in_n, .o_cyc_ack, .o_shared_select_n, .o_bank_one_select_n,
  .o_ata_read_strobe_n, .o_ata_write_strobe_n, .o_read_enable_n,
  .o_buffer_enable_second_n, .o_global_mode, .o_boot_from_rom);

// ### verification/csd_mem_model.sv
// external memory and ata peripheral behind the selects
// assumes selects low active; both answer lines pulled up
module csd_mem_model (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_sel_n,
  input  wire logic       i_ata_n,
  input  wire logic       i_ack_on,
  input  wire logic [7:0] i_delay,
  output logic            o_transfer_ack_in_n,
  output logic            o_ata_ready_in
);
  // ****************
  // answer timing
  // ****************
  logic [7:0] cnt_q;
  always @(posedge i_clk) begin
    if (i_srst || i_sel_n) cnt_q <= 8'h00;
    else if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
  end
  // slow device: ready withheld for i_delay cycles
  always @(posedge i_clk) o_ata_ready_in <= i_srst | i_ata_n | (cnt_q >= i_delay);
  // terminates only when told, else the pull-up wins
  always @(posedge i_clk) begin
    o_transfer_ack_in_n <= i_srst | !i_ack_on | i_sel_n | (cnt_q < i_delay);
  end
endmodule // csd_mem_model

// ### verification/tb.sv
// self-checking bench of the chip-select decoder
// assumes csd_decoder, csd_mem_model and the bound checker
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_srst, i_strap_a23, i_wr_en, i_int_to_ext_ctl, ack_on;
  logic        i_cyc_req, i_cyc_internal, i_cyc_write;
  logic [2:0]  i_wr_idx, i_rd_idx;
  logic [1:0]  i_wr_kind, i_rd_kind;
  logic [31:0] i_wr_data, i_ata_config_first, i_cyc_addr, d;
  logic [3:0]  i_buf2_enable;
  logic [7:0]  dly;
  logic [8:0]  seen;
  wire         i_transfer_ack_in_n, i_ata_ready_in, o_cyc_ack, o_cyc_hang, o_burst;
  wire         o_boot_rom_sel, o_shared_select_n, o_bank_one_select_n, o_global_mode;
  wire         o_ata_read_strobe_n, o_ata_write_strobe_n, o_read_enable_n, o_boot_from_rom;
  wire         o_buffer_enable_first_n, o_buffer_enable_second_n;
  wire  [1:0]  o_port_width;
  wire  [31:0] o_rd_data;
  int          n_errors, num_checks, n;
  csd_decoder dut_u (.i_clk, .i_srst, .i_strap_a23, .i_wr_en, .i_wr_idx, .i_wr_kind,
    .i_wr_data, .i_rd_idx, .i_rd_kind, .o_rd_data, .i_ata_config_first, .i_buf2_enable,
    .i_int_to_ext_ctl, .i_cyc_req, .i_cyc_internal, .i_cyc_write, .i_cyc_addr,
    .i_transfer_ack_in_n, .i_ata_ready_in, .o_cyc_ack, .o_cyc_hang, .o_port_width,
    .o_burst, .o_boot_rom_sel, .o_shared_select_n, .o_bank_one_select_n,
    .o_ata_read_strobe_n, .o_ata_write_strobe_n, .o_read_enable_n,
    .o_buffer_enable_first_n, .o_buffer_enable_second_n, .o_global_mode, .o_boot_from_rom);
  csd_mem_model mem_u (.i_clk, .i_srst, .i_ack_on(ack_on), .i_delay(dly),
    .i_sel_n(o_shared_select_n & o_bank_one_select_n & o_ata_read_strobe_n
      & o_ata_write_strobe_n), .i_ata_n(o_ata_read_strobe_n & o_ata_write_strobe_n),
    .o_transfer_ack_in_n(i_transfer_ack_in_n), .o_ata_ready_in(i_ata_ready_in));
  // ****************
  // helpers
  // ****************
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] ix, input logic [1:0] kd, input logic [31:0] v);
    @(negedge i_clk);
    {i_wr_en, i_wr_idx, i_wr_kind, i_wr_data} = {1'b1, ix, kd, v};
    @(negedge i_clk);
    i_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [2:0] ix, input logic [1:0] kd);
    @(negedge i_clk);
    {i_rd_idx, i_rd_kind} = {ix, kd};
    @(negedge i_clk);
    d = o_rd_data;
  endtask
  // holds the request until ack or mx cycles; n stays 0 on timeout
  task automatic cyc(input logic [31:0] a, input logic w, input int mx);
    @(negedge i_clk);
    {i_cyc_req, i_cyc_addr, i_cyc_write, seen, n} = {1'b1, a, w, 9'h000, 32'h0000_0000};
    for (int k = 1; k <= mx && n == 0; k++) begin
      @(negedge i_clk);
      seen |= ~{~o_cyc_hang, ~o_boot_rom_sel, o_read_enable_n, o_buffer_enable_second_n,
        o_buffer_enable_first_n, o_shared_select_n, o_bank_one_select_n,
        o_ata_write_strobe_n, o_ata_read_strobe_n};
      if (o_cyc_ack === 1'b1) n = k;
    end
    i_cyc_req = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
  task automatic do_reset(input logic s);
    @(negedge i_clk);
    {i_srst, i_strap_a23} = {1'b1, s};
    repeat (6) @(negedge i_clk);
    i_srst = 1'b0;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_global;
    chk("global_mode", 32'h1, o_global_mode);
    chk("port_width", 32'h2, o_port_width);
    rd(3'h0, 2'h2);
    chk("boot_ctrl", 32'h0000_3DA0, d);
    rd(3'h1, 2'h2);
    chk("bank_ctrl", 32'h0, d);
    cyc(32'h7654_0000, 1'b0, 40);
    chk("boot_lat", 32'd17, n);
    chk("boot_seen", 32'h058, seen);
    i_cyc_internal = 1'b1;
    cyc(32'h7654_0000, 1'b0, 30);
    chk("int_ignored", 32'h0, n);
    i_int_to_ext_ctl = 1'b1;
    cyc(32'h7654_0000, 1'b0, 40);
    chk("int_ext_lat", 32'd17, n);
    {i_cyc_internal, i_int_to_ext_ctl} = 2'h0;
    $display("test global done");
  endtask
  task automatic t_program;
    wr(3'h0, 2'h0, 32'h1000_0000);
    wr(3'h0, 2'h1, 32'h0000_0001);
    // global mode drops one cycle after the valid bit lands
    @(negedge i_clk);
    chk("global_off", 32'h0, o_global_mode);
    cyc(32'h1000_1234, 1'b0, 40);
    chk("boot_prog_lat", 32'd17, n);
    wr(3'h1, 2'h0, 32'h2000_0000);
    wr(3'h1, 2'h1, 32'h000F_0001);
    wr(3'h1, 2'h2, 32'h0000_0D90);
    cyc(32'h200F_8000, 1'b0, 40);
    chk("bank_lat", 32'd5, n);
    chk("bank_seen", 32'h044, seen);
    chk("bank_burst", 32'h1, o_burst);
    chk("bank_width", 32'h2, o_port_width);
    cyc(32'h2010_0000, 1'b0, 30);
    chk("miss_seen", 32'h100, seen);
    wr(3'h1, 2'h2, 32'h0000_0080);
    {ack_on, dly} = {1'b1, 8'h04};
    cyc(32'h2000_0000, 1'b1, 40);
    chk("ext_term", 32'h1, n > 5 && n < 40);
    wr(3'h0, 2'h1, 32'h0000_0000);
    chk("global_stays", 32'h0, o_global_mode);
    ack_on = 1'b0;
    $display("test program done");
  endtask
  task automatic t_ata;
    wr(3'h2, 2'h0, 32'h3000_0000);
    wr(3'h2, 2'h1, 32'h0000_0001);
    wr(3'h2, 2'h2, 32'h0000_0080);
    {i_ata_config_first, dly} = {32'h0000_1400, 8'h00};
    cyc(32'h3000_0010, 1'b0, 60);
    chk("ata_long_wait", 32'h1, n > 22);
    chk("ata_rd_seen", 32'h041, seen);
    cyc(32'h3000_0010, 1'b1, 60);
    chk("ata_wr_seen", 32'h002, seen);
    {i_ata_config_first, dly} = {32'h0000_1401, 8'h28};
    cyc(32'h3000_0010, 1'b1, 90);
    chk("ata_wr_both", 32'h003, seen);
    chk("ata_ready_lat", 32'h1, n > 40);
    {i_ata_config_first, dly} = {32'h0, 8'h00};
    wr(3'h2, 2'h0, 32'h2000_0000);
    cyc(32'h2000_0000, 1'b0, 30);
    chk("multi_hold", 32'h0, n);
    ack_on = 1'b1;
    cyc(32'h2000_0000, 1'b0, 40);
    chk("multi_seen", 32'h045, seen);
    ack_on = 1'b0;
    $display("test ata done");
  endtask
  task automatic t_rom;
    do_reset(1'b0);
    chk("rom_boot", 32'h1, o_boot_from_rom);
    rd(3'h2, 2'h0);
    chk("ata_base_kept", 32'h2000_0000, d);
    rd(3'h2, 2'h1);
    chk("ata_valid_clr", 32'h0, d);
    rd(3'h1, 2'h0);
    chk("bank_base_clr", 32'h0, d);
    cyc(32'h0000_0100, 1'b0, 40);
    chk("rom_seen", 32'h080, seen & 9'h088);
    wr(3'h0, 2'h1, 32'h0000_0001);
    wr(3'h3, 2'h0, 32'h4000_0000);
    wr(3'h3, 2'h1, 32'h0000_0001);
    wr(3'h3, 2'h2, 32'h0000_0180);
    i_ata_config_first = 32'h0024_0000;
    cyc(32'h4000_0000, 1'b0, 40);
    chk("pinless_seen", 32'h070, seen);
    wr(3'h4, 2'h0, 32'h5000_0000);
    wr(3'h4, 2'h1, 32'h0000_0001);
    wr(3'h4, 2'h2, 32'h0000_0180);
    {i_ata_config_first, i_buf2_enable} = {32'h0, 4'h8};
    cyc(32'h5000_0000, 1'b0, 40);
    chk("rom_pin_seen", 32'h068, seen);
    $display("test rom done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {i_srst, i_strap_a23, i_wr_en, i_int_to_ext_ctl, ack_on, i_cyc_req} = 6'h20;
    {i_cyc_internal, i_cyc_write, i_wr_idx, i_rd_idx, i_wr_kind, i_rd_kind} = 12'h0;
    {i_wr_data, i_ata_config_first, i_cyc_addr, i_buf2_enable, dly} = 108'h0;
    do_reset(1'b1);
    t_global;
    t_program;
    t_ata;
    t_rom;
    report_and_stop;
  end
  initial begin
    #400_000;
    n_errors++;
    $display("Error watchdog expected done seen hang");
    report_and_stop;
  end
endmodule // tb
